/* File: verilog/bbdp_pkg.sv */
// Purpose: Shared constants for the baseband delay processor
// Assumes: 8-bit register file addressed by register index
// Notes:   Sine table is a 16-step quarter wave, amplitude 127
package bbdp_pkg;
  localparam int          CLK_HZ      = 20_000_000;
  localparam int          CLK_MAX_HZ  = 40_000_000;
  localparam int          SMP_W       = 10;
  localparam int          REG_N       = 13;
  localparam logic [3:0]  REG_DLY0    = 4'h0;
  localparam logic [3:0]  REG_DLY1    = 4'h1;
  localparam logic [3:0]  REG_DLY2    = 4'h2;
  localparam logic [3:0]  REG_PHASE   = 4'h3;
  localparam logic [3:0]  REG_DEC0    = 4'h4;
  localparam logic [3:0]  REG_DEC1    = 4'h5;
  localparam logic [3:0]  REG_DEC2    = 4'h6;
  localparam logic [3:0]  REG_FC0     = 4'h7;
  localparam logic [3:0]  REG_FC1     = 4'h8;
  localparam logic [3:0]  REG_FC2     = 4'h9;
  localparam logic [3:0]  REG_FC3     = 4'ha;
  localparam logic [3:0]  REG_GAIN    = 4'hb;
  localparam logic [3:0]  REG_CTRL    = 4'hc;
  localparam logic [7:0]  MASK_DLY2   = 8'h3f;
  localparam logic [7:0]  MASK_CTRL   = 8'h1f;
  localparam logic [7:0]  REG_RST     = 8'h00;
  localparam int          CTRL_AGC    = 0;
  localparam int          CTRL_PULL   = 1;
  localparam int          CTRL_TEST   = 2;
  localparam int          CTRL_BIAS   = 3;
  localparam int          CTRL_INV    = 4;
  localparam logic [4:0]  DELAY_UNIT  = 5'd25;
  localparam int          BIAS_LOG2   = 10;
  localparam int          AGC_LOG2    = 10;
  localparam logic [8:0]  AGC_HI      = 9'h1c0;
  localparam logic [8:0]  AGC_LO      = 9'h0e0;
  localparam logic [7:0]  AGC_RST     = 8'h80;
  localparam logic [6:0]  SIN_Q [16] = '{
    7'h00, 7'h0c, 7'h19, 7'h25, 7'h31, 7'h3c, 7'h47, 7'h51,
    7'h5a, 7'h62, 7'h6a, 7'h70, 7'h75, 7'h7a, 7'h7d, 7'h7f};
  typedef enum logic [1:0] {
    OS_IDLE = 2'b01,
    OS_RUN  = 2'b10
  } bbdp_out_t;
endpackage

/* File: verilog/bbdp_delay_mem.sv */
// Purpose: Circular sample store for the delay line
// Assumes: One write and one read port on sys_clk
// Notes:   Read data is registered; old data on same-address access
`timescale 1ns/1ps
module bbdp_delay_mem #(
  parameter int DW = 20,
  parameter int AW = 12
) (
  input  wire logic          sys_clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [DW-1:0] wr_data,
  input  wire logic [AW-1:0] rd_addr,
  output logic      [DW-1:0] rd_data
);
  logic [DW-1:0] mem [1<<AW];

  always_ff @(posedge sys_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge sys_clk) begin
    rd_data <= mem[rd_addr];
  end
endmodule

/* File: verilog/bbdp_core.sv */
// Purpose: Baseband mixer, decimator, bias remover, delay line, gain
// Assumes: Upstream and downstream logic clocked by sys_clk
// Notes:   Delay wraps once it exceeds the 2**AW sample store
// Contract
// (R1) Output lags input by delay value times 25 post-decimation samples.
// (R2) Delay is 22 bits from three bytes, top byte bits 5..0; zero legal.
// (R3) With factor D keep one input of every D, drop the rest.
// (R4) Factor 0 or 1 passes every input sample.
// (R5) Decimation factor is 24 bits from three bytes, low byte first.
// (R6) Phase rotated by 360 times phase byte over 256 degrees.
// (R7) Centre frequency word is subtracted from input frequency.
// (R8) Centre frequency spans four bytes, low first, top holds 31..24.
// (R9) Without auto gain, the fixed gain byte drives the receiver gain.
// (R10) Control bit 0 selects fixed gain or automatic gain.
// (R11) Control bit 1 selects pushed or pulled output.
// (R12) Software keeps control bit 2 clear; it is for tests.
// (R13) Control bit 3 removes DC per channel from 1024-sample mean.
// (R14) Control bit 4 inverts the input spectrum.
// (R15) Any write of the control byte resets the output interface.
// (R16) Controller rewrites control byte after pulling modulator changes.
// (R17) Gain loop sees the input as unsigned 10-bit complex samples.
// (R18) Interface signals change after the rising edge; clock at most 40 MHz.
// (R19) Upstream marks each input with a strobe, possibly held high.
// (R20) In push mode output strobe is 1 while enabled, else 0.
// (R21) Registers read and write; undefined registers and bits ignored.
// (R22) Delay is a circular buffer with pointers moved per kept sample.
// (R23) A 32-bit accumulator stepping every clock drives the mixer.
`timescale 1ns/1ps
module bbdp_core #(
  parameter int AW = 12
) (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic [9:0] data_i_in,
  input  wire logic [9:0] data_q_in,
  input  wire logic       sample_strobe_in,
  input  wire logic       pull_req_in,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  output logic      [7:0] reg_rdata,
  output logic      [9:0] data_i_out,
  output logic      [9:0] data_q_out,
  output logic            sample_strobe_out,
  output logic            receiver_gain_pwm
);
  localparam int W = bbdp_pkg::SMP_W;

  logic [7:0]          regs_q [bbdp_pkg::REG_N];
  logic [7:0]          rdata_q;
  logic [W-1:0]        i_s1_q, i_s2_q, q_s1_q, q_s2_q;
  logic                v_s1_q, v_s2_q;
  logic                p_s1_q, p_s2_q, p_s3_q;
  logic [21:0]         dly_val;
  logic [23:0]         dec_val;
  logic [31:0]         fc_val;
  logic [7:0]          ctrl;
  logic                ctrl_wr;

  // (R21) Register write
  assign ctrl_wr = reg_wr && (reg_addr == bbdp_pkg::REG_CTRL);
  always_ff @(posedge sys_clk) begin
    for (int k = 0; k < bbdp_pkg::REG_N; k++) begin
      if (!reset_n) begin
        regs_q[k] <= bbdp_pkg::REG_RST;
      end else if (reg_wr && reg_addr == 4'(k)) begin
        if (4'(k) == bbdp_pkg::REG_DLY2) begin
          regs_q[k] <= reg_wdata & bbdp_pkg::MASK_DLY2;
        end else if (4'(k) == bbdp_pkg::REG_CTRL) begin
          regs_q[k] <= reg_wdata & bbdp_pkg::MASK_CTRL;
        end else begin
          regs_q[k] <= reg_wdata;
        end
      end
    end
  end

  // (R21) Registered readback
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
    end else if (reg_addr < 4'(bbdp_pkg::REG_N)) begin
      rdata_q <= regs_q[reg_addr];
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign reg_rdata = rdata_q;

  // (R2) Delay assembly
  assign dly_val = {regs_q[bbdp_pkg::REG_DLY2][5:0], regs_q[bbdp_pkg::REG_DLY1],
                    regs_q[bbdp_pkg::REG_DLY0]};
  // (R5) Decimation assembly
  assign dec_val = {regs_q[bbdp_pkg::REG_DEC2], regs_q[bbdp_pkg::REG_DEC1],
                    regs_q[bbdp_pkg::REG_DEC0]};
  // (R8) Frequency assembly
  assign fc_val = {regs_q[bbdp_pkg::REG_FC3], regs_q[bbdp_pkg::REG_FC2],
                   regs_q[bbdp_pkg::REG_FC1], regs_q[bbdp_pkg::REG_FC0]};
  // Test bit is stored and read back but drives nothing
  assign ctrl = regs_q[bbdp_pkg::REG_CTRL];

  // (R19) Pin synchronisers
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      i_s1_q <= '0;
      i_s2_q <= '0;
      q_s1_q <= '0;
      q_s2_q <= '0;
      v_s1_q <= 1'b0;
      v_s2_q <= 1'b0;
      p_s1_q <= 1'b0;
      p_s2_q <= 1'b0;
      p_s3_q <= 1'b0;
    end else begin
      i_s1_q <= data_i_in;
      i_s2_q <= i_s1_q;
      q_s1_q <= data_q_in;
      q_s2_q <= q_s1_q;
      v_s1_q <= sample_strobe_in;
      v_s2_q <= v_s1_q;
      p_s1_q <= pull_req_in;
      p_s2_q <= p_s1_q;
      p_s3_q <= p_s2_q;
    end
  end

  // Sine lookup on an 8-bit angle
  function automatic logic signed [7:0] sin_lut(input logic [7:0] a);
    logic [6:0] m;
    m = a[6] ? bbdp_pkg::SIN_Q[4'hf - a[5:2]] : bbdp_pkg::SIN_Q[a[5:2]];
    sin_lut = a[7] ? -$signed({1'b0, m}) : $signed({1'b0, m});
  endfunction

  // (R23) Phase accumulator
  logic [31:0] nco_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      nco_q <= 32'h0000_0000;
    end else begin
      nco_q <= nco_q + fc_val;
    end
  end

  logic signed [W-1:0] in_i, in_q;
  logic [7:0]          ang;
  logic signed [7:0]   sn, cs;
  logic signed [19:0]  mi, mq;
  // Offset-binary input to two's complement
  assign in_i = $signed({~i_s2_q[W-1], i_s2_q[W-2:0]});
  // (R14) Spectrum inversion
  assign in_q = ctrl[bbdp_pkg::CTRL_INV] ?
                -$signed({~q_s2_q[W-1], q_s2_q[W-2:0]}) :
                $signed({~q_s2_q[W-1], q_s2_q[W-2:0]});
  // (R6) (R7) Rotation minus translation
  assign ang = regs_q[bbdp_pkg::REG_PHASE] - nco_q[31:24];
  assign sn  = sin_lut(ang);
  assign cs  = sin_lut(ang + 8'h40);
  assign mi  = 20'(in_i * cs) - 20'(in_q * sn);
  assign mq  = 20'(in_i * sn) + 20'(in_q * cs);

  // Scaling by 256 loses 6 dB but can never overflow
  logic                mix_v_q;
  logic signed [W-1:0] mix_i_q, mix_q_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      mix_v_q <= 1'b0;
      mix_i_q <= '0;
      mix_q_q <= '0;
    end else begin
      mix_v_q <= v_s2_q;
      mix_i_q <= mi[17:8];
      mix_q_q <= mq[17:8];
    end
  end

  // (R4) Bypass for factor 0 or 1
  logic        dec_pass, keep;
  logic [23:0] dec_cnt_q;
  assign dec_pass = (dec_val < 24'h00_0002);
  // (R3) Keep one of D
  assign keep = dec_pass || (dec_cnt_q == 24'h00_0000);
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      dec_cnt_q <= 24'h00_0000;
    end else if (dec_pass) begin
      dec_cnt_q <= 24'h00_0000;
    end else if (mix_v_q) begin
      dec_cnt_q <= (dec_cnt_q >= dec_val - 24'h00_0001) ? 24'h00_0000 :
                   dec_cnt_q + 24'h00_0001;
    end
  end

  logic                dec_v_q;
  logic signed [W-1:0] dec_i_q, dec_q_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      dec_v_q <= 1'b0;
      dec_i_q <= '0;
      dec_q_q <= '0;
    end else begin
      dec_v_q <= mix_v_q && keep;
      if (mix_v_q && keep) begin
        dec_i_q <= mix_i_q;
        dec_q_q <= mix_q_q;
      end
    end
  end

  // (R13) Bias estimate per channel
  localparam int BIAS_W = bbdp_pkg::BIAS_LOG2;
  logic signed [W+BIAS_W-1:0] acc_i_q, acc_q_q;
  logic [BIAS_W-1:0]   bcnt_q;
  logic signed [W-1:0] bias_i_q, bias_q_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      bcnt_q   <= '0;
      acc_i_q  <= '0;
      acc_q_q  <= '0;
      bias_i_q <= '0;
      bias_q_q <= '0;
    end else if (dec_v_q) begin
      bcnt_q <= bcnt_q + 1'b1;
      if (&bcnt_q) begin
        bias_i_q <= W'((acc_i_q + dec_i_q) >>> BIAS_W);
        bias_q_q <= W'((acc_q_q + dec_q_q) >>> BIAS_W);
        acc_i_q  <= '0;
        acc_q_q  <= '0;
      end else begin
        acc_i_q <= acc_i_q + dec_i_q;
        acc_q_q <= acc_q_q + dec_q_q;
      end
    end
  end

  logic                dc_v_q;
  logic signed [W-1:0] dc_i_q, dc_q_q;
  // (R13) Bias subtraction
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      dc_v_q <= 1'b0;
      dc_i_q <= '0;
      dc_q_q <= '0;
    end else begin
      dc_v_q <= dec_v_q;
      if (dec_v_q) begin
        dc_i_q <= ctrl[bbdp_pkg::CTRL_BIAS] ? dec_i_q - bias_i_q : dec_i_q;
        dc_q_q <= ctrl[bbdp_pkg::CTRL_BIAS] ? dec_q_q - bias_q_q : dec_q_q;
      end
    end
  end

  // (R1) Delay in samples
  logic [26:0]   dly_smp;
  logic [AW-1:0] wr_ptr_q, rd_ptr;
  logic [2*W-1:0] rd_word;
  logic          zero_dly;
  assign dly_smp  = 27'(dly_val * bbdp_pkg::DELAY_UNIT);
  assign zero_dly = (dly_val == 22'h00_0000);
  // (R22) Read pointer trails writer
  assign rd_ptr   = wr_ptr_q - dly_smp[AW-1:0];
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      wr_ptr_q <= '0;
    end else if (dc_v_q) begin
      wr_ptr_q <= wr_ptr_q + 1'b1;
    end
  end

  bbdp_delay_mem #(
    .DW (2*W),
    .AW (AW)
  ) i_bbdp_delay_mem (
    .sys_clk (sys_clk),
    .wr_en   (dc_v_q),
    .wr_addr (wr_ptr_q),
    .wr_data ({dc_i_q, dc_q_q}),
    .rd_addr (rd_ptr),
    .rd_data (rd_word)
  );

  // Zero delay bypasses the store, which would return stale data
  logic           dly_v_q, zero_q;
  logic [2*W-1:0] byp_q;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      dly_v_q <= 1'b0;
      zero_q  <= 1'b0;
      byp_q   <= '0;
    end else begin
      dly_v_q <= dc_v_q;
      zero_q  <= zero_dly;
      byp_q   <= {dc_i_q, dc_q_q};
    end
  end

  logic [2*W-1:0] dly_word;
  assign dly_word = zero_q ? byp_q : rd_word;

  // (R11) Flow select
  logic           pull_mode, pull_edge;
  assign pull_mode = ctrl[bbdp_pkg::CTRL_PULL];
  assign pull_edge = p_s2_q && !p_s3_q;

  bbdp_pkg::bbdp_out_t os_q;
  logic [2*W-1:0]      hold_q;
  logic [W-1:0]        oi_q, oq_q;
  logic                ostb_q;

  // (R15) Interface reset on control write
  always_ff @(posedge sys_clk) begin
    if (!reset_n || ctrl_wr) begin
      os_q <= bbdp_pkg::OS_IDLE;
    end else begin
      case (os_q)
        bbdp_pkg::OS_IDLE: begin
          if (pull_mode ? pull_edge : dly_v_q) begin
            os_q <= bbdp_pkg::OS_RUN;
          end
        end
        bbdp_pkg::OS_RUN: begin
          os_q <= bbdp_pkg::OS_RUN;
        end
        default: begin
          os_q <= bbdp_pkg::OS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n || ctrl_wr) begin
      hold_q <= '0;
    end else if (dly_v_q) begin
      hold_q <= dly_word;
    end
  end

  // (R18) Outputs launched from flops
  always_ff @(posedge sys_clk) begin
    if (!reset_n || ctrl_wr) begin
      oi_q   <= '0;
      oq_q   <= '0;
      ostb_q <= 1'b0;
    end else if (pull_mode) begin
      ostb_q <= pull_edge;
      if (pull_edge) begin
        oi_q <= hold_q[2*W-1:W];
        oq_q <= hold_q[W-1:0];
      end
    end else begin
      // (R20) Push strobe level
      ostb_q <= (os_q == bbdp_pkg::OS_RUN) || dly_v_q;
      if (dly_v_q) begin
        oi_q <= dly_word[2*W-1:W];
        oq_q <= dly_word[W-1:0];
      end
    end
  end

  // Back to offset binary to match the input format
  assign data_i_out        = {~oi_q[W-1], oi_q[W-2:0]};
  assign data_q_out        = {~oq_q[W-1], oq_q[W-2:0]};
  assign sample_strobe_out = ostb_q;

  // (R17) Unsigned input magnitude
  logic [8:0]  mag_i, mag_q, mag;
  assign mag_i = i_s2_q[W-1] ? i_s2_q[8:0] : ~i_s2_q[8:0];
  assign mag_q = q_s2_q[W-1] ? q_s2_q[8:0] : ~q_s2_q[8:0];
  assign mag   = (mag_i > mag_q) ? mag_i : mag_q;

  logic [bbdp_pkg::AGC_LOG2-1:0] acnt_q;
  logic [8:0]  peak_q;
  logic [7:0]  agc_q, gain, pwm_cnt_q;
  logic        pwm_q;
  // Peak over a window; higher setting means less gain
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      acnt_q <= '0;
      peak_q <= 9'h000;
      agc_q  <= bbdp_pkg::AGC_RST;
    end else if (v_s2_q) begin
      acnt_q <= acnt_q + 1'b1;
      if (&acnt_q) begin
        peak_q <= 9'h000;
        if (peak_q > bbdp_pkg::AGC_HI && agc_q != 8'hff) begin
          agc_q <= agc_q + 8'h01;
        end else if (peak_q < bbdp_pkg::AGC_LO && agc_q != 8'h00) begin
          agc_q <= agc_q - 8'h01;
        end
      end else if (mag > peak_q) begin
        peak_q <= mag;
      end
    end
  end

  // (R9) (R10) Gain source select
  assign gain = ctrl[bbdp_pkg::CTRL_AGC] ? agc_q : regs_q[bbdp_pkg::REG_GAIN];

  // Duty of gain/256; full scale high means least gain
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      pwm_cnt_q <= 8'h00;
      pwm_q     <= 1'b0;
    end else begin
      pwm_cnt_q <= pwm_cnt_q + 8'h01;
      pwm_q     <= (pwm_cnt_q < gain);
    end
  end
  assign receiver_gain_pwm = pwm_q;
endmodule

/* File: verification/bbdp_core_assertions.sv */
// Purpose: Port-level checks for bbdp_core
// Assumes: Control and gain bytes shadowed from the write port
// Notes:   Pull answer window allows one cycle of slack
`timescale 1ns/1ps
module bbdp_core_assertions #(
  parameter int AW = 12
) (
  input wire logic       sys_clk,
  input wire logic       reset_n,
  input wire logic       pull_req_in,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_rdata,
  input wire logic       sample_strobe_out,
  input wire logic       receiver_gain_pwm
);
  logic [7:0] ctrl_q;
  logic [7:0] gain_q;
  logic [9:0] idle_q;
  logic       ctl_wr;
  assign ctl_wr = reg_wr && reg_addr == 4'hc;
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl_q <= 8'h00;
    end else if (ctl_wr) begin
      ctrl_q <= reg_wdata;
    end
  end
  // Idle count lets a pwm period run out after a gain change
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      gain_q <= 8'h00;
      idle_q <= 10'h000;
    end else if (ctl_wr || (reg_wr && reg_addr == 4'hb)) begin
      gain_q <= ctl_wr ? gain_q : reg_wdata;
      idle_q <= 10'h000;
    end else if (idle_q != 10'h3ff) begin
      idle_q <= idle_q + 10'h001;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  sequence s_gain_wr;
    reg_wr && reg_addr == 4'hb ##1 reg_addr == 4'hb;
  endsequence
  sequence s_dly2_wr;
    reg_wr && reg_addr == 4'h2 ##1 reg_addr == 4'h2;
  endsequence
  a_ctrl_wr_clears: assert property (ctl_wr |-> ##[1:2] !sample_strobe_out)
    else $error("strobe not cleared by control write");
  a_push_strobe_holds: assert property (
    !ctrl_q[1] && !ctl_wr && !$past(ctl_wr) && sample_strobe_out |=> sample_strobe_out)
    else $error("push strobe dropped");
  a_pull_pulse_once: assert property (
    ctrl_q[1] && !ctl_wr && sample_strobe_out |=> !sample_strobe_out)
    else $error("pull strobe longer than one cycle");
  a_pull_answer: assert property (
    ctrl_q[1] && !ctl_wr && $rose(pull_req_in) |-> ##[3:4] sample_strobe_out)
    else $error("pull request not answered");
  a_undef_reads_zero: assert property (reg_addr > 4'hc |=> reg_rdata == 8'h00)
    else $error("undefined register read nonzero");
  a_gain_readback: assert property (s_gain_wr |=> reg_rdata == $past(reg_wdata, 2))
    else $error("gain byte read back wrong");
  a_dly2_mask: assert property (
    s_dly2_wr |=> reg_rdata == ($past(reg_wdata, 2) & 8'h3f))
    else $error("delay top byte mask wrong");
  a_ctrl_bits_zero: assert property (reg_addr == 4'hc |=> reg_rdata[7:5] == 3'h0)
    else $error("undefined control bits read nonzero");
  a_fixed_gain_zero: assert property (
    !ctrl_q[0] && idle_q == 10'h3ff && gain_q == 8'h00 |-> !receiver_gain_pwm)
    else $error("gain output high at gain zero");
endmodule
bind bbdp_core bbdp_core_assertions #(.AW(AW)) i_bbdp_core_assertions (
  .sys_clk(sys_clk), .reset_n(reset_n), .pull_req_in(pull_req_in),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
  .sample_strobe_out(sample_strobe_out), .receiver_gain_pwm(receiver_gain_pwm)
);

/* File: verification/bbdp_far_end.sv */
// Purpose: Upstream sample source and downstream puller
// Assumes: Input strobe held high, one sample per clock
// Notes:   Pulled samples are counted, not stored
`timescale 1ns/1ps
module bbdp_far_end (
  input  wire logic       sys_clk,
  input  wire logic       sample_strobe_out,
  output logic      [9:0] data_i_in,
  output logic      [9:0] data_q_in,
  output logic            sample_strobe_in,
  output logic            pull_req_in
);
  int pulses = 0;
  initial begin
    data_i_in = 10'h200;
    data_q_in = 10'h200;
    sample_strobe_in = 1'b1;
    pull_req_in = 1'b0;
  end
  // called just after a falling edge
  task automatic hold(input logic [9:0] i, input logic [9:0] q);
    data_i_in = i;
    data_q_in = q;
  endtask
  task automatic pull(input int gap);
    @(negedge sys_clk);
    pull_req_in = 1'b1;
    @(negedge sys_clk);
    pull_req_in = 1'b0;
    repeat (gap) @(negedge sys_clk);
  endtask
  always @(posedge sys_clk) begin
    if (sample_strobe_out === 1'b1) begin
      pulses++;
    end
  end
endmodule

/* File: verification/tb_baseband_delay_processor.sv */
// Purpose: Self-checking bench for the baseband delay processor
// Assumes: Delay store cut to 2**8 samples to keep runs short
// Notes:   Data checks look at sign and timing, not exact mixer gain
`timescale 1ns/1ps
module tb_baseband_delay_processor;
  logic       sys_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic [7:0] reg_rdata;
  logic [9:0] data_i_in;
  logic [9:0] data_q_in;
  logic [9:0] data_i_out;
  logic [9:0] data_q_out;
  logic       sample_strobe_in;
  logic       pull_req_in;
  logic       sample_strobe_out;
  logic       receiver_gain_pwm;
  logic [7:0] rv;
  logic [7:0] ev;
  int         bad_count = 0;
  int         total_checks = 0;
  int         cycles = 0;
  int         n;
  int         k;
  int         tk[9] = '{0, 0, 1, 2, 1, 0, 0, 0, 0};
  int         td[9] = '{0, 1, 0, 1, 3, 2, 0, 0, 0};
  int         tei[9] = '{1, 2, 1, 1, 1, 1, 0, 3, 3};
  int         teq[9] = '{0, 0, 0, 0, 0, 0, 2, 1, 2};
  always #25 sys_clk = ~sys_clk;
  bbdp_core #(.AW(8)) i_bbdp_core (
    .sys_clk(sys_clk), .reset_n(reset_n), .data_i_in(data_i_in), .data_q_in(data_q_in),
    .sample_strobe_in(sample_strobe_in), .pull_req_in(pull_req_in), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rdata(reg_rdata),
    .data_i_out(data_i_out), .data_q_out(data_q_out),
    .sample_strobe_out(sample_strobe_out), .receiver_gain_pwm(receiver_gain_pwm)
  );
  bbdp_far_end i_bbdp_far_end (
    .sys_clk(sys_clk), .sample_strobe_out(sample_strobe_out), .data_i_in(data_i_in),
    .data_q_in(data_q_in), .sample_strobe_in(sample_strobe_in), .pull_req_in(pull_req_in)
  );
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (bad_count == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk_val(input logic [9:0] got, input logic [9:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int lo, input int hi, input string m);
    total_checks++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("CHECK FAILED %0t %s got %0d", $time, m, got);
    end
  endtask
  // Sign class of an offset binary sample; unknown never matches
  function automatic int sgn(input logic [9:0] x);
    return $isunknown(x) ? 9 : (x === 10'h200) ? 0 : x[9] ? 1 : 2;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  task automatic do_reset();
    @(negedge sys_clk);
    reset_n = 1'b0;
    repeat (12) @(negedge sys_clk);
    reset_n = 1'b1;
  endtask
  // One marker sample through delay, decimation, rotation and inversion
  task automatic run(input int r);
    int dd;
    int t;
    int b;
    dd = (td[r] < 2) ? 1 : td[r];
    b = 25 * tk[r] * dd;
    wr(4'h0, 8'(tk[r]));
    wr(4'h4, 8'(td[r]));
    wr(4'h3, (r == 7) ? 8'h40 : (r == 8) ? 8'hc0 : 8'h00);
    wr(4'hc, (r == 6) ? 8'h10 : 8'h00);
    // Flush old markers out of the 256-sample store
    repeat (800) @(negedge sys_clk);
    chk_val({9'h000, sample_strobe_out}, 10'h001, "push strobe");
    i_bbdp_far_end.hold((r == 6) ? 10'h200 : (r == 1) ? 10'h000 : 10'h3ff,
                        (r == 6) ? 10'h300 : 10'h200);
    repeat (dd) @(negedge sys_clk);
    i_bbdp_far_end.hold(10'h200, 10'h200);
    t = dd;
    while (data_i_out === 10'h200 && data_q_out === 10'h200 && t < 300) begin
      @(negedge sys_clk);
      t++;
    end
    chk_cnt(t, b + 7, b + 7 + dd, "latency");
    if (tei[r] != 3) chk_cnt(sgn(data_i_out), tei[r], tei[r], "i sign");
    chk_cnt(sgn(data_q_out), teq[r], teq[r], "q sign");
  endtask
  initial begin
    do_reset();
    chk_val(data_i_out, 10'h200, "idle data");
    for (n = 0; n < 16; n++) begin
      rd(4'(n), rv);
      chk_val({2'b00, rv}, 10'h000, "reset value");
    end
    for (n = 0; n < 14; n++) begin
      ev = (n == 2) ? 8'h3f : (n == 12) ? 8'h1b : (n == 13) ? 8'h00 : 8'hff;
      wr(4'(n), (n == 12) ? 8'hfb : 8'hff);
      rd(4'(n), rv);
      chk_val({2'b00, rv}, {2'b00, ev}, "read back");
    end
    do_reset();
    rd(4'hb, rv);
    chk_val({2'b00, rv}, 10'h000, "second reset");
    for (n = 0; n < 9; n++) run(n);
    wr(4'h3, 8'h00);
    wr(4'hc, 8'h08);
    i_bbdp_far_end.hold(10'h280, 10'h200);
    repeat (500) @(negedge sys_clk);
    chk_cnt(sgn(data_i_out), 1, 1, "bias early");
    repeat (2000) @(negedge sys_clk);
    chk_cnt(sgn(data_i_out), 0, 0, "bias removed");
    // quarter-turn word spins a steady I input through +, 0, -, 0
    wr(4'hc, 8'h00);
    wr(4'ha, 8'h40);
    i_bbdp_far_end.hold(10'h3ff, 10'h200);
    repeat (20) @(negedge sys_clk);
    k = 0;
    repeat (8) begin
      @(negedge sys_clk);
      k += (sgn(data_i_out) == 1) ? 1 : (sgn(data_i_out) == 2) ? 10 : 0;
    end
    chk_cnt(k, 22, 22, "frequency spin");
    i_bbdp_far_end.hold(10'h200, 10'h200);
    // duty follows fixed gain, auto gain starts mid-scale
    for (n = 0; n < 4; n++) begin
      ev = (n == 1) ? 8'h40 : (n == 2) ? 8'hff : 8'h00;
      wr(4'hb, ev);
      wr(4'hc, (n == 3) ? 8'h01 : 8'h00);
      repeat (300) @(negedge sys_clk);
      k = 0;
      repeat (512) begin
        @(negedge sys_clk);
        if (receiver_gain_pwm === 1'b1) k++;
      end
      if (n < 3) chk_cnt(k, 2 * ev, 2 * ev, "fixed duty");
      else chk_cnt(k, 200, 312, "auto duty");
    end
    // one strobe per request, fast and slow
    wr(4'hc, 8'h02);
    repeat (20) @(negedge sys_clk);
    i_bbdp_far_end.pulses = 0;
    for (n = 0; n < 4; n++) i_bbdp_far_end.pull((n < 2) ? 2 : 9);
    repeat (10) @(negedge sys_clk);
    chk_cnt(i_bbdp_far_end.pulses, 4, 4, "pull count");
    stop_test();
  end
endmodule
